//--- design/line_metadata_inserter.sv
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// Operation
// - insertion enable and settings take effect only at channel activation; off by default
// - enabling insertion on an unsupported camera configuration sets an error flag
// - insertion refused when lookup table, colour conversion or depth reduction is on
// - one, two or three fields inserted, count set by tap layout and tap arrangement
// - line-start placement replaces the whole first slot after line valid rises
// - first-tap placement replaces port A for ten link cycles per line
// - tenth-tap placement replaces port J for ten link cycles per line
// - tenth-tap placement drives zero on port J in all other cycles
// - placement defaults to line start, which every configuration accepts
// - first-tap placement only for medium four-tap 8-bit, four-region geometry
// - tenth-tap placement only for ten-tap 8-bit, single-region ten-tap geometry
// - 32-bit general pulse counter, usable only with three fields
// - general pulse count sampled at line valid rise into its field
// - general counter off by default; source one counts input one rising edges
// - general count field omitted, replaces line count, or replaces encoder count
// - with clear source four, a high input four clears the general counter
// - 6-bit raw input level field sampled at line valid rise
// - 32-bit line valid counter, wraps, incremented before insertion
// - three fields are input state, line count, encoder count, in order
// - 32-bit encoder counter counts decoder pulses and wraps
module line_metadata_inserter (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cl_clk_pin,
    input wire meta_pkg::pix_t cl_pix_pin,
    input wire logic [meta_pkg::ISO_W-1:0] iso_in,
    input wire logic enc_pulse,
    output meta_pkg::pix_t out_pix,
    output logic out_strobe
);
    import meta_pkg::*;

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [1:0] fields_of(input logic [2:0] lay,
                                             input logic [2:0] arr);
        logic [1:0] n;
        n = 2'h0;
        case (lay)
            LAY_ONE_FIELD: n = 2'h1;
            LAY_TWO_FIELD: n = 2'h2;
            LAY_THREE_FIELD: n = 2'h3;
            LAY_MEDIUM_FOUR_TAP_8BIT: n = (arr == ARR_FOUR_REGION) ? 2'h3 : 2'h1;
            LAY_TEN_TAP_8BIT: n = (arr == ARR_SINGLE_REGION_TEN_TAP) ? 2'h3 : 2'h1;
            default: n = 2'h0;
        endcase
        return n;
    endfunction

    // field bytes: byte0 input state, bytes 1..4 field two, 5..8 field three
    function automatic logic [DATA_W-1:0] build_meta(input logic [ISO_W-1:0] io,
                                                     input logic [CNT_W-1:0] f2,
                                                     input logic [CNT_W-1:0] f3,
                                                     input logic [1:0] nf);
        logic [DATA_W-1:0] m;
        m = '0;
        m[7:0] = {2'h0, io};
        if (nf >= 2'h2) m[8 +: CNT_W] = f2;
        if (nf == 2'h3) m[8+CNT_W +: CNT_W] = f3;
        return m;
    endfunction

    function automatic logic [7:0] byte_of(input logic [DATA_W-1:0] m,
                                           input logic [3:0] idx);
        return m[idx*8 +: 8];
    endfunction

    // ************************************************************
    // pin synchronisation and link edge detection
    // ************************************************************
    logic [SYNC_W-1:0] sync_q;
    logic lclk_s;
    pix_t pix_s;
    logic [ISO_W-1:0] iso_s;
    logic lclk_prev_r;
    logic lval_prev_r;
    logic iso_one_prev_r;
    logic link_edge;
    logic lval_rise;

    pin_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk(clk),
        .srst(srst),
        .d({cl_clk_pin, cl_pix_pin, iso_in}),
        .q(sync_q)
    );

    assign lclk_s = sync_q[SYNC_W-1];
    assign pix_s = pix_t'(sync_q[ISO_W +: PIX_W]);
    assign iso_s = sync_q[ISO_W-1:0];
    assign link_edge = lclk_s & ~lclk_prev_r;
    assign lval_rise = link_edge & pix_s.lval & ~lval_prev_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            lclk_prev_r <= 1'b0;
            lval_prev_r <= 1'b0;
            iso_one_prev_r <= 1'b0;
        end else begin
            lclk_prev_r <= lclk_s;
            iso_one_prev_r <= iso_s[ISO_ONE];
            if (link_edge) lval_prev_r <= pix_s.lval;
        end
    end

    // ************************************************************
    // register bus
    // ************************************************************
    logic wb_ack_r;
    logic [31:0] wb_dat_r;
    logic [7:0] ctrl_r;
    logic [10:0] cfg_r;
    logic activate_r;
    logic err_r;
    logic wb_req;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_status;

    logic act_en_r;
    place_t act_place_r;
    gp_place_t act_gpl_r;
    logic [1:0] act_nf_r;
    logic act_src_r;
    logic act_clrsrc_r;
    logic [CNT_W-1:0] line_cnt_r;
    logic [CNT_W-1:0] enc_cnt_r;
    logic [CNT_W-1:0] gp_cnt_r;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_r;
    assign wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADDR_CTRL);
    assign wr_cfg = wb_req & wb_we_i & (wb_adr_i == ADDR_CFG);
    assign wr_status = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADDR_STATUS);

    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack_r <= wb_req;
            if (wb_req) begin
                case (wb_adr_i)
                    ADDR_CTRL: wb_dat_r <= {25'h0, ctrl_r[6:0]};
                    ADDR_CFG: wb_dat_r <= {21'h0, cfg_r};
                    ADDR_STATUS: wb_dat_r <= {27'h0, lval_prev_r, err_r,
                                              act_en_r ? act_nf_r : 2'h0, act_en_r};
                    ADDR_LINE: wb_dat_r <= line_cnt_r;
                    ADDR_ENC: wb_dat_r <= enc_cnt_r;
                    ADDR_GP: wb_dat_r <= gp_cnt_r;
                    default: wb_dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_r <= CTRL_RESET;
            cfg_r <= CFG_RESET;
            activate_r <= 1'b0;
        end else begin
            activate_r <= wr_ctrl & wb_dat_i[CTRL_ACT];
            if (wr_ctrl) ctrl_r <= {1'b0, wb_dat_i[6:0]};
            if (wr_cfg && wb_sel_i[0]) cfg_r[7:0] <= wb_dat_i[7:0];
            if (wr_cfg && wb_sel_i[1]) cfg_r[10:8] <= wb_dat_i[10:8];
        end
    end

    // ************************************************************
    // activation and compatibility check
    // ************************************************************
    logic [1:0] cfg_nf;
    logic proc_conflict;
    logic place_ok;
    logic compat;

    assign cfg_nf = fields_of(cfg_r[CFG_LAYOUT +: 3], cfg_r[CFG_ARR +: 3]);
    assign proc_conflict = cfg_r[CFG_LUT] | cfg_r[CFG_CFA] | cfg_r[CFG_DEPTH];

    always_comb begin
        place_ok = 1'b0;
        case (ctrl_r[CTRL_PLACE +: 2])
            PL_LINE_START: place_ok = 1'b1;
            PL_FIRST_TAP: place_ok = (cfg_r[CFG_LAYOUT +: 3] == LAY_MEDIUM_FOUR_TAP_8BIT)
                && (cfg_r[CFG_ARR +: 3] == ARR_FOUR_REGION);
            PL_TENTH_TAP: place_ok = (cfg_r[CFG_LAYOUT +: 3] == LAY_TEN_TAP_8BIT)
                && (cfg_r[CFG_ARR +: 3] == ARR_SINGLE_REGION_TEN_TAP);
            default: place_ok = 1'b0;
        endcase
    end

    assign compat = (cfg_nf != 2'h0) & ~proc_conflict & place_ok;

    always_ff @(posedge clk) begin
        if (srst) begin
            act_en_r <= 1'b0;
            act_place_r <= PL_LINE_START;
            act_gpl_r <= GPPL_NONE;
            act_nf_r <= 2'h0;
            act_src_r <= 1'b0;
            act_clrsrc_r <= 1'b0;
        end else if (activate_r) begin
            act_en_r <= ctrl_r[CTRL_EN] & compat;
            act_place_r <= place_t'(ctrl_r[CTRL_PLACE +: 2]);
            act_gpl_r <= gp_place_t'(ctrl_r[CTRL_GPPL +: 2]);
            act_nf_r <= cfg_nf;
            act_src_r <= ctrl_r[CTRL_SRC];
            act_clrsrc_r <= ctrl_r[CTRL_CLRSRC];
        end
    end

    // error flag: a new failure wins over a write-one clear
    always_ff @(posedge clk) begin
        if (srst) begin
            err_r <= 1'b0;
        end else if (activate_r && ctrl_r[CTRL_EN] && !compat) begin
            err_r <= 1'b1;
        end else if (wr_status && wb_dat_i[ST_ERR]) begin
            err_r <= 1'b0;
        end
    end

    // ************************************************************
    // counters
    // ************************************************************
    logic gp_run;
    logic gp_clear;

    assign gp_run = act_en_r & (act_nf_r == 2'h3) & act_src_r;
    assign gp_clear = act_clrsrc_r & iso_s[ISO_FOUR];

    always_ff @(posedge clk) begin
        if (srst) line_cnt_r <= '0;
        else if (lval_rise) line_cnt_r <= line_cnt_r + 32'h0000_0001;
    end

    always_ff @(posedge clk) begin
        if (srst) enc_cnt_r <= '0;
        else if (enc_pulse) enc_cnt_r <= enc_cnt_r + 32'h0000_0001;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gp_cnt_r <= '0;
        end else if (gp_clear) begin
            gp_cnt_r <= '0;
        end else if (gp_run && iso_s[ISO_ONE] && !iso_one_prev_r) begin
            gp_cnt_r <= gp_cnt_r + 32'h0000_0001;
        end
    end

    // ************************************************************
    // metadata snapshot at line start
    // ************************************************************
    logic [CNT_W-1:0] field2;
    logic [CNT_W-1:0] field3;
    logic [1:0] nf_use;
    logic [DATA_W-1:0] meta_now;
    logic [DATA_W-1:0] meta_r;

    always_comb begin
        nf_use = act_nf_r;
        field2 = line_cnt_r + 32'h0000_0001;
        field3 = enc_cnt_r;
        if (act_nf_r == 2'h3 && act_gpl_r == GPPL_LINE) field2 = gp_cnt_r;
        if (act_nf_r == 2'h3 && act_gpl_r == GPPL_ENC) field3 = gp_cnt_r;
    end

    assign meta_now = build_meta(iso_s, field2, field3, nf_use);

    always_ff @(posedge clk) begin
        if (srst) meta_r <= '0;
        else if (lval_rise) meta_r <= meta_now;
    end

    // ************************************************************
    // line phase tracking
    // ************************************************************
    typedef enum logic [2:0] {
        LN_IDLE = 3'b001,
        LN_META = 3'b010,
        LN_BODY = 3'b100
    } line_st_t;

    line_st_t line_st_r;
    logic [3:0] slot_r;
    logic [3:0] slot_nxt;

    assign slot_nxt = slot_r + 4'h1;

    always_ff @(posedge clk) begin
        if (srst) begin
            line_st_r <= LN_IDLE;
            slot_r <= 4'h0;
        end else if (link_edge) begin
            if (!pix_s.lval) begin
                line_st_r <= LN_IDLE;
            end else if (lval_rise) begin
                line_st_r <= LN_META;
                slot_r <= 4'h0;
            end else if (line_st_r == LN_META) begin
                slot_r <= slot_nxt;
                if (slot_nxt == 4'(META_CYCLES - 1)) line_st_r <= LN_BODY;
            end
        end
    end

    // ************************************************************
    // substitution
    // ************************************************************
    pix_t pix_mod;
    logic [7:0] tap_byte;
    logic in_meta;

    assign in_meta = (line_st_r == LN_META) & pix_s.lval & ~lval_rise;

    always_comb begin
        tap_byte = 8'h00;
        if (lval_rise) tap_byte = meta_now[7:0];
        else if (in_meta) tap_byte = byte_of(meta_r, slot_nxt);
    end

    always_comb begin
        pix_mod = pix_s;
        if (act_en_r) begin
            unique case (act_place_r)
                PL_LINE_START: begin
                    if (lval_rise) pix_mod.data = meta_now;
                end
                PL_FIRST_TAP: begin
                    if (lval_rise || in_meta) pix_mod.data[7:0] = tap_byte;
                end
                PL_TENTH_TAP: begin
                    pix_mod.data[DATA_W-1 -: 8] = tap_byte;
                end
                default: pix_mod = pix_s;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            out_pix <= '0;
            out_strobe <= 1'b0;
        end else begin
            out_strobe <= link_edge;
            if (link_edge) out_pix <= pix_mod;
        end
    end

    assign wb_ack_o = wb_ack_r;
    assign wb_dat_o = wb_dat_r;

    // ************************************************************
    // assertions
    // ************************************************************
    ack_single_a: assert property (@(posedge clk) disable iff (srst)
        wb_ack_r |=> !wb_ack_r) else $error("ack held two cycles");

    act_hold_a: assert property (@(posedge clk) disable iff (srst)
        !activate_r |=> $stable(act_en_r)) else $error("enable changed without activation");

    err_set_a: assert property (@(posedge clk) disable iff (srst)
        activate_r && ctrl_r[CTRL_EN] && !compat |=> err_r && !act_en_r)
        else $error("incompatible enable not flagged");

    proc_block_a: assert property (@(posedge clk) disable iff (srst)
        activate_r && proc_conflict |=> !act_en_r)
        else $error("insertion enabled with pixel processing");

    line_start_a: assert property (@(posedge clk) disable iff (srst)
        lval_rise && act_en_r && act_place_r == PL_LINE_START
        |=> out_pix.data == $past(meta_now))
        else $error("first slot not replaced");

    first_tap_a: assert property (@(posedge clk) disable iff (srst)
        link_edge && act_en_r && act_place_r == PL_FIRST_TAP
        |=> out_pix.data[DATA_W-1:8] == $past(pix_s.data[DATA_W-1:8]))
        else $error("first-tap placement touched other ports");

    tenth_zero_a: assert property (@(posedge clk) disable iff (srst)
        link_edge && act_en_r && act_place_r == PL_TENTH_TAP
        && line_st_r == LN_BODY |=> out_pix.data[DATA_W-1 -: 8] == 8'h00)
        else $error("port J not zero after metadata");

    line_cnt_a: assert property (@(posedge clk) disable iff (srst)
        lval_rise |=> line_cnt_r == $past(line_cnt_r) + 32'h0000_0001)
        else $error("line counter missed a line");

    enc_cnt_a: assert property (@(posedge clk) disable iff (srst)
        enc_pulse |=> enc_cnt_r == $past(enc_cnt_r) + 32'h0000_0001)
        else $error("encoder counter missed a pulse");

    gp_clear_a: assert property (@(posedge clk) disable iff (srst)
        gp_clear |=> gp_cnt_r == 32'h0000_0000)
        else $error("general counter not cleared");

    pass_thru_a: assert property (@(posedge clk) disable iff (srst)
        link_edge && !act_en_r |=> out_pix == $past(pix_s) && out_strobe)
        else $error("disabled path altered data");

endmodule // line_metadata_inserter

//--- common/meta_pkg.sv
package meta_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int PORTS = 10;
    localparam int DATA_W = PORTS * 8;
    localparam int ISO_W = 6;
    localparam int CNT_W = 32;
    localparam int ISO_ONE = 0;
    localparam int ISO_FOUR = 3;
    localparam int META_CYCLES = 10;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_LINE = 8'h0C;
    localparam logic [7:0] ADDR_ENC = 8'h10;
    localparam logic [7:0] ADDR_GP = 8'h14;

    // control fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_PLACE = 1;
    localparam int CTRL_SRC = 3;
    localparam int CTRL_GPPL = 4;
    localparam int CTRL_CLRSRC = 6;
    localparam int CTRL_ACT = 7;
    // configuration fields
    localparam int CFG_LAYOUT = 0;
    localparam int CFG_ARR = 3;
    localparam int CFG_LUT = 8;
    localparam int CFG_CFA = 9;
    localparam int CFG_DEPTH = 10;
    // status fields
    localparam int ST_ACTIVE = 0;
    localparam int ST_NF = 1;
    localparam int ST_ERR = 3;
    localparam int ST_LVAL = 4;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [10:0] CFG_RESET = 11'h000;

    // ************************************************************
    // encodings
    // ************************************************************
    typedef enum logic [1:0] {
        PL_LINE_START = 2'h0,
        PL_FIRST_TAP = 2'h1,
        PL_TENTH_TAP = 2'h2
    } place_t;

    typedef enum logic [1:0] {
        GPPL_NONE = 2'h0,
        GPPL_LINE = 2'h1,
        GPPL_ENC = 2'h2
    } gp_place_t;

    typedef enum logic [2:0] {
        LAY_UNSUPPORTED = 3'h0,
        LAY_ONE_FIELD = 3'h1,
        LAY_TWO_FIELD = 3'h2,
        LAY_THREE_FIELD = 3'h3,
        LAY_MEDIUM_FOUR_TAP_8BIT = 3'h4,
        LAY_TEN_TAP_8BIT = 3'h5
    } tap_layout_t;

    typedef enum logic [2:0] {
        ARR_OTHER = 3'h0,
        ARR_FOUR_REGION = 3'h1,
        ARR_SINGLE_REGION_TEN_TAP = 3'h2
    } tap_arrangement_t;

    typedef struct packed {
        logic lval;
        logic [DATA_W-1:0] data;
    } pix_t;

    localparam int PIX_W = DATA_W + 1;
    localparam int SYNC_W = 1 + PIX_W + ISO_W;

endpackage

//--- design/pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the clock domain
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // pin_sync

//--- dv/cam_model.sv
`timescale 1ns/1ps
// camera side: the link clock runs only during a line() call, its gap cycles and the cycle after lval included
module cam_model (
    output logic cl_clk_pin,
    output meta_pkg::pix_t cl_pix_pin
);
    import meta_pkg::*;

    initial begin
        cl_clk_pin = 1'b0;
        cl_pix_pin = '0;
    end

    // data moves on the falling link edge; words outside lval change every cycle
    task automatic line(input int gap, input int len, input logic [DATA_W-1:0] base);
        int i;
        #7;
        for (i = 0; i <= gap + len; i++) begin
            cl_clk_pin = 1'b0;
            cl_pix_pin.lval = (i >= gap) && (i < gap + len);
            cl_pix_pin.data = cl_pix_pin.lval ? base + DATA_W'(i) : ~(base + DATA_W'(i));
            #80;
            cl_clk_pin = 1'b1;
            #80;
        end
        cl_clk_pin = 1'b0;
        cl_pix_pin.data = ~cl_pix_pin.data;
    endtask
endmodule // cam_model

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
    import meta_pkg::*;
    localparam int GAP = 2;
    localparam int LEN = 12;
    logic clk = 1'b0;
    logic srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cl_clk_pin, enc_pulse, out_strobe;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0] wb_sel_i;
    logic [ISO_W-1:0] iso_in;
    pix_t cl_pix_pin, out_pix;
    wire [PIX_W-1:0] out_vec = out_pix;
    int n_errors = 0;
    int checks = 0;
    logic [PIX_W-1:0] pix_q[$];
    logic [31:0] rd_q[$];
    logic [15:0] seed = 16'h005C;
    logic act, src, clr;
    logic [1:0] pl, nf, gpl;
    logic [31:0] nl, enc, gp;
    // entries: control byte, configuration, expected field count (0 = refused or not enabled)
    logic [20:0] tbl [14] = '{{8'h81, 11'h000, 2'h0}, {8'h81, 11'h103, 2'h0},
        {8'h81, 11'h203, 2'h0}, {8'h81, 11'h403, 2'h0},
        {8'h83, 11'h015, 2'h0}, {8'h85, 11'h00C, 2'h0},
        {8'h81, 11'h001, 2'h1}, {8'h81, 11'h002, 2'h2}, {8'h81, 11'h003, 2'h3},
        {8'h81, 11'h004, 2'h1}, {8'h81, 11'h015, 2'h3},
        {8'h83, 11'h00C, 2'h3}, {8'h85, 11'h015, 2'h3},
        {8'h80, 11'h003, 2'h0}};

    always #10 clk = ~clk;

    line_metadata_inserter line_metadata_inserter_inst (
        .clk(clk),
        .srst(srst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .cl_clk_pin(cl_clk_pin),
        .cl_pix_pin(cl_pix_pin),
        .iso_in(iso_in),
        .enc_pulse(enc_pulse),
        .out_pix(out_pix),
        .out_strobe(out_strobe)
    );

    cam_model cam_model_inst (
        .cl_clk_pin(cl_clk_pin),
        .cl_pix_pin(cl_pix_pin)
    );

    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction

    task automatic cmp(input logic [80:0] got, input logic [80:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int t;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 100);
        cmp(t < 100, 1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wb_rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic act_cfg(input logic [20:0] e);
        logic [7:0] c;
        logic err;
        c = e[20:13];
        xfer(1'b1, ADDR_CFG, {21'h0, e[12:2]});
        xfer(1'b1, ADDR_CTRL, {24'h0, c});
        act = c[0] && e[1:0] != 2'h0;
        err = c[0] && e[1:0] == 2'h0;
        nf = act ? e[1:0] : 2'h0;
        {clr, gpl, src, pl} = c[6:1];
        wb_rd(ADDR_STATUS, {28'h0, err, nf, act});
        wb_rd(ADDR_CTRL, {25'h0, c[6:0]});
        if (err) begin
            xfer(1'b1, ADDR_STATUS, 32'h8);
            wb_rd(ADDR_STATUS, 32'h0);
        end
    endtask

    task automatic enc_pulses(input logic [1:0] n);
        repeat (n) begin
            enc_pulse <= 1'b1;
            @(posedge clk);
            enc_pulse <= 1'b0;
            @(posedge clk);
            enc = enc + 32'h1;
        end
    endtask

    task automatic iso_pulses(input int n);
        repeat (n) begin
            iso_in[0] <= 1'b1;
            repeat (4) @(posedge clk);
            iso_in[0] <= 1'b0;
            repeat (4) @(posedge clk);
            if (act && nf == 2'h3 && src) gp = gp + 32'h1;
        end
    endtask

    task automatic run_line();
        logic [DATA_W-1:0] base, w, m;
        logic lv;
        int i, k;
        base = {rnd(), rnd(), rnd(), rnd(), rnd()};
        nl = nl + 32'h1;
        m = {8'h00, (nf == 2'h3) ? ((gpl == GPPL_ENC) ? gp : enc) : 32'h0,
            (nf >= 2'h2) ? ((gpl == GPPL_LINE) ? gp : nl) : 32'h0, 2'b00, iso_in};
        for (i = 0; i <= GAP + LEN; i++) begin
            k = i - GAP;
            lv = k >= 0 && k < LEN;
            w = lv ? base + DATA_W'(i) : ~(base + DATA_W'(i));
            if (act && pl == PL_LINE_START && k == 0) w = m;
            if (act && pl == PL_FIRST_TAP && lv && k < META_CYCLES) w[7:0] = m[8*k +: 8];
            if (act && pl == PL_TENTH_TAP)
                w[79:72] = (lv && k < META_CYCLES) ? m[8*k +: 8] : 8'h00;
            pix_q.push_back({lv, w});
        end
        cam_model_inst.line(GAP, LEN, base);
        repeat (8) @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (out_strobe === 1'b1) begin
            cmp(out_vec, (pix_q.size() != 0) ? pix_q.pop_front() : ~out_vec);
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            cmp(wb_dat_o, (rd_q.size() != 0) ? rd_q.pop_front() : ~wb_dat_o);
        end
    end

    initial begin
        #500_000;
        n_errors++;
        $display("Error at %0t: no progress", $time);
        wrap_up();
    end

    initial begin
        int i;
        logic [15:0] r;
        srst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, enc_pulse} = 4'h0;
        {wb_adr_i, wb_dat_i, iso_in} = '0;
        wb_sel_i = 4'hF;
        {act, src, clr, pl, nf, gpl} = '0;
        {nl, enc, gp} = '0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        wb_rd(ADDR_CTRL, 32'h0);
        wb_rd(ADDR_CFG, 32'h0);
        wb_rd(ADDR_STATUS, 32'h0);
        wb_rd(ADDR_GP, 32'h0);
        wb_rd(8'h1C, 32'h0);
        $display("test reset_values done");
        xfer(1'b1, ADDR_CFG, 32'h3);
        xfer(1'b1, ADDR_CTRL, 32'h1);
        run_line();
        wb_rd(ADDR_STATUS, 32'h0);
        run_line();
        wb_rd(ADDR_LINE, nl);
        $display("test pass_through done");
        for (i = 0; i < 14; i++) begin
            act_cfg(tbl[i]);
            r = rnd();
            iso_in <= r[5:0];
            enc_pulses(r[9:8]);
            @(posedge clk);
            run_line();
        end
        wb_rd(ADDR_ENC, enc);
        wb_rd(ADDR_LINE, nl);
        $display("test placements done");
        iso_in <= 6'h00;
        act_cfg({8'hD9, 11'h003, 2'h3});
        iso_pulses(3);
        run_line();
        iso_in[3] <= 1'b1;
        repeat (4) @(posedge clk);
        iso_in[3] <= 1'b0;
        gp = 32'h0;
        iso_pulses(2);
        run_line();
        wb_rd(ADDR_GP, gp);
        act_cfg({8'hA9, 11'h003, 2'h3});
        iso_in[3] <= 1'b1;
        @(posedge clk);
        iso_pulses(2);
        run_line();
        wb_rd(ADDR_GP, gp);
        $display("test pulse_counter done");
        repeat (10) @(posedge clk);
        cmp(pix_q.size() + rd_q.size(), 0);
        wrap_up();
    end
endmodule // tb
